//--- design/serial_link_consts.svh
// Offsets, field positions and reset values of the serial link parameter registers.
`ifndef SERIAL_LINK_CONSTS_SVH
`define SERIAL_LINK_CONSTS_SVH

`define OFS_LANE7_IDENT 12'h058A
`define OFS_SCRAMBLE_LANES 12'h058B
`define OFS_OCTETS_FRAME 12'h058C
`define OFS_FRAMES_MF 12'h058D
`define OFS_CONV_COUNT 12'h058E

`define SCR_BIT 7
`define LANE_HI 4
`define LANE_LO 0
`define RSVD_SCR_HI 6
`define RSVD_SCR_LO 5
`define FRAMES_HI 4
`define FRAMES_LO 0
`define LID_HI 4
`define LID_LO 0

`define RST_SCRAMBLE 1'h1
`define RST_LANE_FIELD 5'h07
`define RST_OCTET_FIELD 8'h00
`define RST_FRAME_FIELD 5'h1F
`define RST_CONV_FIELD 8'h01
`define RST_LANE7_ID 5'h07

`define LANES_ONE 5'h00
`define LANES_TWO 5'h01
`define LANES_FOUR 5'h03
`define LANES_EIGHT 5'h07
`define OCT_F1 8'h00
`define OCT_F2 8'h01
`define OCT_F3 8'h02
`define OCT_F4 8'h03
`define OCT_F6 8'h05
`define OCT_F8 8'h07
`define OCT_F16 8'h0F
`define CONV_ONE 8'h00
`define CONV_TWO 8'h01
`define CONV_FOUR 8'h03
`define CONV_EIGHT 8'h07
`define MF_ALIGN_MASK 14'h0003

`endif

//--- design/serial_link_pkg.sv
// Types shared by the serial link parameter registers and their users.
package serial_link_pkg;

  typedef logic [11:0] reg_addr_t;
  typedef logic [7:0] reg_data_t;

  // Decoded link parameters as the framing and lane logic consumes them.
  typedef struct packed {
    logic scramble_en;
    logic [5:0] lane_count;
    logic [8:0] octets_per_frame;
    logic [5:0] frames_per_mf;
    logic [8:0] converter_count;
    logic [4:0] lane7_id;
    logic cfg_supported;
  } link_cfg_s;

endpackage : serial_link_pkg

//--- design/serial_link_param_regs.sv
// Configuration register bank for the transmit link framing parameters.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/10ps
`include "serial_link_consts.svh"

// Function
// - Bit 7 of scramble/lane register enables scrambler; resets to one.
// - Lane field 0,1,3,7 gives 1,2,4,8 lanes; resets to 7.
// - Octets per frame is field plus one; field resets to zero.
// - Frames per multiframe is five-bit field plus one; resets to 0x1F.
// - Eight-bit converter field resets to one; zero means one converter.
// - Converter field 1, 3, 7 means two, four, eight converters.
// - Writable five-bit lane seven identifier, reset 7, sent on link.
module serial_link_param_regs (
  input wire logic CLK,
  input wire logic RST_N,
  input wire serial_link_pkg::reg_addr_t ADDR,
  input wire serial_link_pkg::reg_data_t WDATA,
  input wire logic WR,
  input wire logic RD,
  output serial_link_pkg::reg_data_t RDATA,
  output serial_link_pkg::link_cfg_s LINK_CFG
);
  import serial_link_pkg::*;

  logic scramble_r;
  logic [4:0] lane_field_r;
  logic [7:0] octet_field_r;
  logic [4:0] frame_field_r;
  logic [7:0] conv_field_r;
  logic [4:0] lane7_id_r;
  reg_data_t rdata_r;
  reg_data_t rdata_nxt;
  link_cfg_s cfg_r;
  link_cfg_s cfg_nxt;
  logic [13:0] mf_octets;

  // Writes only land in the implemented bits; reserved bits have no storage.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      scramble_r <= `RST_SCRAMBLE;
      lane_field_r <= `RST_LANE_FIELD;
    end else if (WR && ADDR == `OFS_SCRAMBLE_LANES) begin
      scramble_r <= WDATA[`SCR_BIT];
      lane_field_r <= WDATA[`LANE_HI:`LANE_LO];
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      octet_field_r <= `RST_OCTET_FIELD;
    end else if (WR && ADDR == `OFS_OCTETS_FRAME) begin
      octet_field_r <= WDATA;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      frame_field_r <= `RST_FRAME_FIELD;
    end else if (WR && ADDR == `OFS_FRAMES_MF) begin
      frame_field_r <= WDATA[`FRAMES_HI:`FRAMES_LO];
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      conv_field_r <= `RST_CONV_FIELD;
    end else if (WR && ADDR == `OFS_CONV_COUNT) begin
      conv_field_r <= WDATA;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      lane7_id_r <= `RST_LANE7_ID;
    end else if (WR && ADDR == `OFS_LANE7_IDENT) begin
      lane7_id_r <= WDATA[`LID_HI:`LID_LO];
    end
  end

  // Read mux; unmapped addresses and reserved bits answer zero.
  always_comb begin
    rdata_nxt = '0;
    case (ADDR)
      `OFS_LANE7_IDENT: begin
        rdata_nxt[`LID_HI:`LID_LO] = lane7_id_r;
      end
      `OFS_SCRAMBLE_LANES: begin
        rdata_nxt[`SCR_BIT] = scramble_r;
        rdata_nxt[`LANE_HI:`LANE_LO] = lane_field_r;
      end
      `OFS_OCTETS_FRAME: begin
        rdata_nxt = octet_field_r;
      end
      `OFS_FRAMES_MF: begin
        rdata_nxt[`FRAMES_HI:`FRAMES_LO] = frame_field_r;
      end
      `OFS_CONV_COUNT: begin
        rdata_nxt = conv_field_r;
      end
      default: begin
        rdata_nxt = '0;
      end
    endcase
  end

  // Read data stand only in the cycle after the read strobe, zero otherwise.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_r <= '0;
    end else if (RD) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= '0;
    end
  end

  assign RDATA = rdata_r;

  // The octet span of one multiframe; only its low two bits matter.
  assign mf_octets = ({6'h00, octet_field_r} + 14'h0001) * ({9'h000, frame_field_r} + 14'h0001);

  // Counts follow field plus one for every field; unlisted encodings still decode
  // that way, and the supported flag tells the lane logic not to trust them.
  always_comb begin
    cfg_nxt = '0;
    cfg_nxt.scramble_en = scramble_r;
    cfg_nxt.lane_count = {1'b0, lane_field_r} + 6'h01;
    cfg_nxt.octets_per_frame = {1'b0, octet_field_r} + 9'h001;
    cfg_nxt.frames_per_mf = {1'b0, frame_field_r} + 6'h01;
    cfg_nxt.converter_count = {1'b0, conv_field_r} + 9'h001;
    cfg_nxt.lane7_id = lane7_id_r;
    cfg_nxt.cfg_supported = 1'b1;
    case (lane_field_r)
      `LANES_ONE, `LANES_TWO, `LANES_FOUR, `LANES_EIGHT: begin
      end
      default: begin
        cfg_nxt.cfg_supported = 1'b0;
      end
    endcase
    case (octet_field_r)
      `OCT_F1, `OCT_F2, `OCT_F3, `OCT_F4, `OCT_F6, `OCT_F8, `OCT_F16: begin
      end
      default: begin
        cfg_nxt.cfg_supported = 1'b0;
      end
    endcase
    case (conv_field_r)
      `CONV_ONE, `CONV_TWO, `CONV_FOUR, `CONV_EIGHT: begin
      end
      default: begin
        cfg_nxt.cfg_supported = 1'b0;
      end
    endcase
    // Software is trusted to keep the multiframe a whole number of words; a
    // violation is only reported, since the link cannot repair it.
    if ((mf_octets & `MF_ALIGN_MASK) != 14'h0000) begin
      cfg_nxt.cfg_supported = 1'b0;
    end
  end

  // Registered so the far logic sees glitch-free parameters, at one cycle of lag.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_r <= '0;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  assign LINK_CFG = cfg_r;

  // Checks look at LINK_CFG two edges after a write strobe, because the
  // decoded parameters pass one register stage after the field itself.
  // Field registers are sampled directly where only the decode is at stake.

  chk_scramble_follows_write: assert property (
    @(posedge CLK) disable iff (!RST_N)
    (WR && ADDR == `OFS_SCRAMBLE_LANES) ##1 (!(WR && ADDR == `OFS_SCRAMBLE_LANES))
    |=> LINK_CFG.scramble_en == $past(WDATA[`SCR_BIT], 2))
    else $error("Scrambler enable does not follow the written bit.");

  chk_lane_count_decode: assert property (
    @(posedge CLK) disable iff (!RST_N)
    (WR && ADDR == `OFS_SCRAMBLE_LANES && WDATA[`LANE_HI:`LANE_LO] == `LANES_FOUR)
    ##1 (!WR) |=> LINK_CFG.lane_count == 6'h04)
    else $error("Lane field three did not give four lanes.");

  chk_octet_count_plus: assert property (
    @(posedge CLK) disable iff (!RST_N)
    (WR && ADDR == `OFS_OCTETS_FRAME) ##1 (!(WR && ADDR == `OFS_OCTETS_FRAME))
    |=> LINK_CFG.octets_per_frame == {1'b0, $past(WDATA, 2)} + 9'h001)
    else $error("Octets per frame is not the field plus one.");

  chk_frame_count_plus: assert property (
    @(posedge CLK) disable iff (!RST_N)
    $rose(RST_N) |-> frame_field_r == `RST_FRAME_FIELD ##1 LINK_CFG.frames_per_mf == 6'h20)
    else $error("Frames per multiframe does not start at thirty-two.");

  chk_conv_zero_one: assert property (
    @(posedge CLK) disable iff (!RST_N)
    conv_field_r == `CONV_ONE |=> LINK_CFG.converter_count == 9'h001)
    else $error("Converter field zero did not give one converter.");

  chk_conv_eight: assert property (
    @(posedge CLK) disable iff (!RST_N)
    conv_field_r == `CONV_EIGHT
      |=> LINK_CFG.converter_count == 9'h008)
    else $error("Converter field seven did not give eight converters.");

  chk_lane7_readback: assert property (
    @(posedge CLK) disable iff (!RST_N)
    (WR && ADDR == `OFS_LANE7_IDENT) ##1 (RD && ADDR == `OFS_LANE7_IDENT && !WR)
    |=> RDATA == {3'h0, $past(WDATA[`LID_HI:`LID_LO], 2)} ##1 LINK_CFG.lane7_id == lane7_id_r)
    else $error("Lane seven identifier did not read back or reach the link.");

  chk_reserved_read_zero: assert property (
    @(posedge CLK) disable iff (!RST_N)
    (RD && ADDR == `OFS_SCRAMBLE_LANES) |=> RDATA[`RSVD_SCR_HI:`RSVD_SCR_LO] == 2'h0
      && RDATA[`SCR_BIT] == scramble_r)
    else $error("Reserved scramble register bits read nonzero.");

endmodule : serial_link_param_regs

//--- test/link_rx_model.sv
// Behavioural link receiver that adopts the lane count the device announces.
`timescale 1ns/10ps
module link_rx_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire serial_link_pkg::link_cfg_s cfg,
  output logic [5:0] lanes
);
  import serial_link_pkg::*;
  // A receiver ignores a setup the device flags as unsupported, so it keeps the last good one.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lanes <= 6'h00;
    end else if (cfg.cfg_supported) begin
      lanes <= cfg.lane_count;
    end
  end
endmodule : link_rx_model

//--- test/test_serial_link_param_regs.sv
// Self-checking bench for the serial link parameter registers.
`timescale 1ns/10ps
`include "serial_link_consts.svh"
module test_serial_link_param_regs;
  import serial_link_pkg::*;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  reg_addr_t addr = 12'h000;
  reg_data_t wdata = 8'h00;
  logic wr = 1'h0;
  logic rd = 1'h0;
  reg_data_t rdata;
  link_cfg_s cfg;
  logic [5:0] rx_lanes;
  logic [5:0] rx_exp = 6'h08;
  reg_data_t s = 8'h87, f = 8'h00, k = 8'h1F, m = 8'h01, l = 8'h07;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  always #2.5 clk = ~clk;
  serial_link_param_regs dut_u (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .LINK_CFG(cfg));
  link_rx_model rx_u (.clk(clk), .rst_n(rst_n), .cfg(cfg), .lanes(rx_lanes));
  task automatic complete_run();
    $display("Mismatches %0d, compares %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  // The whole run needs well under a thousand cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic cmp_reg(input reg_data_t got, input reg_data_t exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_reg
  task automatic cmp_cfg(input link_cfg_s got, input link_cfg_s exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_cfg
  task automatic put(input reg_addr_t a, input reg_data_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
    case (a)
      `OFS_LANE7_IDENT: l = d & 8'h1F;
      `OFS_SCRAMBLE_LANES: s = d & 8'h9F;
      `OFS_OCTETS_FRAME: f = d;
      `OFS_FRAMES_MF: k = d & 8'h1F;
      `OFS_CONV_COUNT: m = d;
      default: ;
    endcase
  endtask : put
  task automatic rd_chk(input reg_addr_t a, input reg_data_t exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 cmp_reg(rdata, exp);
  endtask : rd_chk
  task automatic wr_rd_lid(input reg_data_t d);
    @(posedge clk);
    addr <= `OFS_LANE7_IDENT;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    l = d & 8'h1F;
    #1 cmp_reg(rdata, l);
  endtask : wr_rd_lid
  function automatic link_cfg_s mk();
    link_cfg_s c;
    c.scramble_en = s[`SCR_BIT];
    c.lane_count = {1'b0, s[4:0]} + 6'h01;
    c.octets_per_frame = {1'b0, f} + 9'h001;
    c.frames_per_mf = {1'b0, k[4:0]} + 6'h01;
    c.converter_count = {1'b0, m} + 9'h001;
    c.lane7_id = l[4:0];
    c.cfg_supported = (s[4:0] inside {5'h00, 5'h01, 5'h03, 5'h07}) &&
      (f inside {8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h07, 8'h0F}) &&
      (m inside {8'h00, 8'h01, 8'h03, 8'h07}) &&
      ((int'(c.octets_per_frame) * int'(c.frames_per_mf)) % 4 == 0);
    return c;
  endfunction : mk
  task automatic chk_all();
    link_cfg_s e;
    e = mk();
    rd_chk(`OFS_LANE7_IDENT, l);
    rd_chk(`OFS_SCRAMBLE_LANES, s);
    rd_chk(`OFS_OCTETS_FRAME, f);
    rd_chk(`OFS_FRAMES_MF, k);
    rd_chk(`OFS_CONV_COUNT, m);
    cmp_cfg(cfg, e);
    if (e.cfg_supported) begin
      rx_exp = e.lane_count;
    end
    cmp_reg({2'h0, rx_lanes}, {2'h0, rx_exp});
  endtask : chk_all
  task automatic t_lanes();
    reg_data_t v[6] = '{8'h00, 8'h81, 8'h03, 8'hE7, 8'h02, 8'h7F};
    foreach (v[i]) begin
      put(`OFS_SCRAMBLE_LANES, v[i]);
      chk_all();
    end
  endtask : t_lanes
  task automatic t_frames();
    reg_data_t fv[8] = '{8'h00, 8'h01, 8'h02, 8'h02, 8'h03, 8'h05, 8'h07, 8'h0F};
    reg_data_t kv[8] = '{8'hFF, 8'h01, 8'h00, 8'h03, 8'h00, 8'h01, 8'h00, 8'h00};
    put(`OFS_SCRAMBLE_LANES, 8'h83);
    foreach (fv[i]) begin
      put(`OFS_FRAMES_MF, kv[i]);
      put(`OFS_OCTETS_FRAME, fv[i]);
      chk_all();
    end
  endtask : t_frames
  task automatic t_conv();
    reg_data_t v[5] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h02};
    foreach (v[i]) begin
      put(`OFS_CONV_COUNT, v[i]);
      chk_all();
    end
  endtask : t_conv
  task automatic t_lid();
    put(`OFS_LANE7_IDENT, 8'hF3);
    wr_rd_lid(8'hEC);
    put(12'h0590, 8'hFF);
    rd_chk(12'h0590, 8'h00);
    chk_all();
  endtask : t_lid
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    chk_all();
    t_lanes();
    t_frames();
    t_conv();
    t_lid();
    complete_run();
  end
endmodule : test_serial_link_param_regs
